/* design/dpm_bank.v */
`timescale 1ns/10ps
`include "dpm_map.vh"

module dpm_bank #(
  parameter NUM_ENT = `DPM_NUM_ENT,
  parameter CNT_W = `DPM_CNT_W
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // ingress packet
  input wire pkt_valid,
  input wire pkt_is_ip,
  input wire [5:0] pkt_dscp,
  // priority result
  output wire pri_valid,
  output wire [`DPM_PRI_W-1:0] pri_value,
  output wire pri_remapped,
  output wire pri_in_bank
);

// ----------------------------------------
// declarations
// ----------------------------------------
wire wr_en;
wire [`DPM_IDX_W-1:0] wr_idx;
wire [7:0] wr_data;
wire [`DPM_IDX_W-1:0] rd_idx;
reg [31:0] rd_data;
wire [`DPM_PRI_W*NUM_ENT-1:0] lo_flat;
wire [`DPM_PRI_W*NUM_ENT-1:0] hi_flat;
reg remap_en;
reg [CNT_W-1:0] hit_cnt;
reg [CNT_W-1:0] next_hit_cnt;
reg [`DPM_ENT_W-1:0] next_ent;
reg next_half;
reg next_in_bank;
reg [`DPM_PRI_W-1:0] next_sel;
reg [`DPM_PRI_W-1:0] next_pri;
reg next_remapped;
wire cnt_clr;
wire cnt_inc;

// ----------------------------------------
// entry index of each mapping byte
// ----------------------------------------
function [`DPM_IDX_W-1:0] ent_idx;
  input integer n;
  begin
    case (n)
      0: ent_idx = `DPM_IDX_1A_1B;
      1: ent_idx = `DPM_IDX_1C_1D;
      2: ent_idx = `DPM_IDX_1E_1F;
      3: ent_idx = `DPM_IDX_20_21;
      4: ent_idx = `DPM_IDX_22_23;
      5: ent_idx = `DPM_IDX_24_25;
      6: ent_idx = `DPM_IDX_26_27;
      7: ent_idx = `DPM_IDX_28_29;
      8: ent_idx = `DPM_IDX_2A_2B;
      9: ent_idx = `DPM_IDX_2C_2D;
      default: ent_idx = {`DPM_IDX_W{1'b1}};
    endcase
  end
endfunction

// ----------------------------------------
// bus slave
// ----------------------------------------
dpm_ahb_slv u_slv (
  .clk(clk),
  .sys_rst(sys_rst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hready(hready),
  .hwdata(hwdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .wr_en(wr_en),
  .wr_idx(wr_idx),
  .wr_data(wr_data),
  .rd_idx(rd_idx),
  .rd_data(rd_data)
);

// ----------------------------------------
// mapping bytes
// ----------------------------------------
genvar gi;
generate
  for (gi = 0; gi < NUM_ENT; gi = gi + 1) begin : g_ent
    reg [`DPM_PRI_W-1:0] lo;
    reg [`DPM_PRI_W-1:0] hi;
    wire hit;
    assign hit = wr_en && (wr_idx == ent_idx(gi));
    assign lo_flat[gi*`DPM_PRI_W +: `DPM_PRI_W] = lo;
    assign hi_flat[gi*`DPM_PRI_W +: `DPM_PRI_W] = hi;
    always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        lo <= `DPM_MAP_RST; // see (RL13)
        hi <= `DPM_MAP_RST; // see (RL13)
      end else if (hit) begin
        lo <= wr_data[`DPM_LO_MSB:`DPM_LO_LSB]; // see (RL13)
        hi <= wr_data[`DPM_HI_MSB:`DPM_HI_LSB]; // see (RL13)
      end
    end
  end
endgenerate

// ----------------------------------------
// control register
// ----------------------------------------
always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    remap_en <= `DPM_CTRL_RST;
  end else if (wr_en && (wr_idx == `DPM_IDX_CTRL)) begin
    remap_en <= wr_data[`DPM_CTRL_EN_BIT];
  end
end

// ----------------------------------------
// in-bank hit counter, clear then increment, both in one cycle give one
// ----------------------------------------
assign cnt_clr = wr_en && (wr_idx == `DPM_IDX_CNT);
assign cnt_inc = pkt_valid && next_in_bank && next_remapped;

always @* begin
  next_hit_cnt = hit_cnt;
  if (cnt_clr) begin
    next_hit_cnt = {CNT_W{1'b0}};
  end
  if (cnt_inc) begin
    next_hit_cnt = next_hit_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
  end
end

always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    hit_cnt <= `DPM_CNT_RST;
  end else begin
    hit_cnt <= next_hit_cnt;
  end
end

// ----------------------------------------
// read mux, reserved bits read zero
// ----------------------------------------
always @* begin
  rd_data = 32'h00000000;
  case (rd_idx)
    `DPM_IDX_1A_1B: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_1A_1B*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_1A_1B*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_1C_1D: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_1C_1D*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_1C_1D*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_1E_1F: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_1E_1F*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_1E_1F*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_20_21: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_20_21*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_20_21*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_22_23: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_22_23*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_22_23*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_24_25: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_24_25*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_24_25*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_26_27: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_26_27*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_26_27*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_28_29: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_28_29*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_28_29*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_2A_2B: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_2A_2B*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_2A_2B*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_2C_2D: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = lo_flat[`DPM_E_2C_2D*`DPM_PRI_W +: `DPM_PRI_W];
      rd_data[`DPM_HI_MSB:`DPM_HI_LSB] = hi_flat[`DPM_E_2C_2D*`DPM_PRI_W +: `DPM_PRI_W];
    end
    `DPM_IDX_CTRL: begin
      rd_data[`DPM_CTRL_EN_BIT] = remap_en;
    end
    `DPM_IDX_STAT: begin
      rd_data[`DPM_LO_MSB:`DPM_LO_LSB] = pri_value;
      rd_data[`DPM_HI_LSB] = pri_in_bank;
      rd_data[`DPM_HI_LSB+1] = pri_remapped;
    end
    `DPM_IDX_CNT: begin
      rd_data[CNT_W-1:0] = hit_cnt;
    end
    default: begin
      rd_data = 32'h00000000;
    end
  endcase
end

// ----------------------------------------
// dscp to table entry and half
// ----------------------------------------
always @* begin
  next_ent = `DPM_E_1A_1B;
  next_half = 1'b0;
  next_in_bank = 1'b1;
  case (pkt_dscp)
    `DPM_DSCP_1A: begin
      next_ent = `DPM_E_1A_1B; // see (RL3)
    end
    `DPM_DSCP_1B: begin
      next_ent = `DPM_E_1A_1B; // see (RL3)
      next_half = 1'b1;
    end
    `DPM_DSCP_1C: begin
      next_ent = `DPM_E_1C_1D; // see (RL4)
    end
    `DPM_DSCP_1D: begin
      next_ent = `DPM_E_1C_1D; // see (RL4)
      next_half = 1'b1;
    end
    `DPM_DSCP_1E: begin
      next_ent = `DPM_E_1E_1F; // see (RL5)
    end
    `DPM_DSCP_1F: begin
      next_ent = `DPM_E_1E_1F; // see (RL5)
      next_half = 1'b1;
    end
    `DPM_DSCP_20: begin
      next_ent = `DPM_E_20_21; // see (RL6)
    end
    `DPM_DSCP_21: begin
      next_ent = `DPM_E_20_21; // see (RL6)
      next_half = 1'b1;
    end
    `DPM_DSCP_22: begin
      next_ent = `DPM_E_22_23; // see (RL7)
    end
    `DPM_DSCP_23: begin
      next_ent = `DPM_E_22_23; // see (RL7)
      next_half = 1'b1;
    end
    `DPM_DSCP_24: begin
      next_ent = `DPM_E_24_25; // see (RL8)
    end
    `DPM_DSCP_25: begin
      next_ent = `DPM_E_24_25; // see (RL8)
      next_half = 1'b1;
    end
    `DPM_DSCP_26: begin
      next_ent = `DPM_E_26_27; // see (RL9)
    end
    `DPM_DSCP_27: begin
      next_ent = `DPM_E_26_27; // see (RL9)
      next_half = 1'b1;
    end
    `DPM_DSCP_28: begin
      next_ent = `DPM_E_28_29; // see (RL10)
    end
    `DPM_DSCP_29: begin
      next_ent = `DPM_E_28_29; // see (RL10)
      next_half = 1'b1;
    end
    `DPM_DSCP_2A: begin
      next_ent = `DPM_E_2A_2B; // see (RL11)
    end
    `DPM_DSCP_2B: begin
      next_ent = `DPM_E_2A_2B; // see (RL11)
      next_half = 1'b1;
    end
    `DPM_DSCP_2C: begin
      next_ent = `DPM_E_2C_2D; // see (RL12)
    end
    `DPM_DSCP_2D: begin
      next_ent = `DPM_E_2C_2D; // see (RL12)
      next_half = 1'b1;
    end
    default: begin
      next_in_bank = 1'b0;
    end
  endcase
end

// ----------------------------------------
// priority selection
// ----------------------------------------
always @* begin
  if (next_half) begin
    next_sel = hi_flat[next_ent*`DPM_PRI_W +: `DPM_PRI_W];
  end else begin
    next_sel = lo_flat[next_ent*`DPM_PRI_W +: `DPM_PRI_W];
  end
end

always @* begin
  next_pri = `DPM_MAP_RST;
  next_remapped = 1'b0;
  if (!pkt_is_ip) begin
    next_pri = `DPM_MAP_RST;
  end else if (!remap_en) begin
    next_pri = pkt_dscp[`DPM_DSCP_CLS_MSB:`DPM_DSCP_CLS_LSB]; // see (RL1)
  end else begin
    next_remapped = 1'b1;
    if (next_in_bank) begin
      next_pri = next_sel; // see (RL2)
    end
  end
end

// ----------------------------------------
// registered result
// ----------------------------------------
dpm_pri_out u_out (
  .clk(clk),
  .sys_rst(sys_rst),
  .in_valid(pkt_valid),
  .in_pri(next_pri),
  .in_remapped(next_remapped),
  .in_bank(next_in_bank && next_remapped),
  .pri_valid(pri_valid),
  .pri_value(pri_value),
  .pri_remapped(pri_remapped),
  .pri_in_bank(pri_in_bank)
);

endmodule // dpm_bank

/* design/dpm_map.vh */
// Summary of operation
// (RL1) remap off: priority is dscp bits 5:3; code gives 0 for non-ip packets
// (RL2) remap on: priority from selected table entry; code gives 0 for dscp outside 1a-2d and for non-ip packets
// (RL3) dscp 1a/1b use byte 34d low/high
// (RL4) dscp 1c/1d use byte 34e low/high
// (RL5) dscp 1e/1f use byte 34f low/high
// (RL6) dscp 20/21 use byte 350 low/high
// (RL7) dscp 22/23 use byte 351 low/high
// (RL8) dscp 24/25 use next byte low/high
// (RL9) dscp 26/27 use byte 353 low/high
// (RL10) dscp 28/29 use byte 354 low/high
// (RL11) dscp 2a/2b use byte 355 low/high
// (RL12) dscp 2c/2d use last byte low/high
// (RL13) bits 7,3 read zero; fields rw, reset zero
`ifndef DPM_MAP_VH
`define DPM_MAP_VH

// ----------------------------------------
// register indices, byte address is index*4
// ----------------------------------------
`define DPM_IDX_W 12
`define DPM_IDX_1A_1B 12'h34d
`define DPM_IDX_1C_1D 12'h34e
`define DPM_IDX_1E_1F 12'h34f
`define DPM_IDX_20_21 12'h350
`define DPM_IDX_22_23 12'h351
`define DPM_IDX_24_25 12'h352
`define DPM_IDX_26_27 12'h353
`define DPM_IDX_28_29 12'h354
`define DPM_IDX_2A_2B 12'h355
`define DPM_IDX_2C_2D 12'h356
`define DPM_IDX_CTRL 12'h3f0
`define DPM_IDX_STAT 12'h3f1
`define DPM_IDX_CNT 12'h3f2

// ----------------------------------------
// bus decode
// ----------------------------------------
`define DPM_ADDR_LSB 2
`define DPM_ADDR_MSB 13
`define DPM_HTRANS_NONSEQ 2'h2
`define DPM_HSIZE_WORD 3'h2
`define DPM_RESP_OKAY 1'h0

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DPM_PRI_W 3
`define DPM_LO_MSB 2
`define DPM_LO_LSB 0
`define DPM_HI_MSB 6
`define DPM_HI_LSB 4
`define DPM_MAP_RST 3'h0
`define DPM_NUM_ENT 10
`define DPM_ENT_W 4
`define DPM_CTRL_EN_BIT 0
`define DPM_CTRL_RST 1'h0
`define DPM_CNT_W 16
`define DPM_CNT_RST 16'h0000
`define DPM_DSCP_CLS_MSB 5
`define DPM_DSCP_CLS_LSB 3

// ----------------------------------------
// table entries and dscp codes
// ----------------------------------------
`define DPM_E_1A_1B 4'h0
`define DPM_E_1C_1D 4'h1
`define DPM_E_1E_1F 4'h2
`define DPM_E_20_21 4'h3
`define DPM_E_22_23 4'h4
`define DPM_E_24_25 4'h5
`define DPM_E_26_27 4'h6
`define DPM_E_28_29 4'h7
`define DPM_E_2A_2B 4'h8
`define DPM_E_2C_2D 4'h9
`define DPM_DSCP_1A 6'h1a
`define DPM_DSCP_1B 6'h1b
`define DPM_DSCP_1C 6'h1c
`define DPM_DSCP_1D 6'h1d
`define DPM_DSCP_1E 6'h1e
`define DPM_DSCP_1F 6'h1f
`define DPM_DSCP_20 6'h20
`define DPM_DSCP_21 6'h21
`define DPM_DSCP_22 6'h22
`define DPM_DSCP_23 6'h23
`define DPM_DSCP_24 6'h24
`define DPM_DSCP_25 6'h25
`define DPM_DSCP_26 6'h26
`define DPM_DSCP_27 6'h27
`define DPM_DSCP_28 6'h28
`define DPM_DSCP_29 6'h29
`define DPM_DSCP_2A 6'h2a
`define DPM_DSCP_2B 6'h2b
`define DPM_DSCP_2C 6'h2c
`define DPM_DSCP_2D 6'h2d

`endif

/* design/dpm_ahb_slv.v */
`timescale 1ns/10ps
`include "dpm_map.vh"

module dpm_ahb_slv (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // ahb-lite
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // register side
  output wire wr_en,
  output wire [`DPM_IDX_W-1:0] wr_idx,
  output wire [7:0] wr_data,
  output wire [`DPM_IDX_W-1:0] rd_idx,
  input wire [31:0] rd_data
);

reg ph_wr;
reg ph_rd;
reg [`DPM_IDX_W-1:0] ph_idx;
wire accept;
wire in_map;

// ----------------------------------------
// address phase
// ----------------------------------------
assign accept = hsel && hready && htrans[1];
assign in_map = (haddr[31:`DPM_ADDR_MSB+1] == 18'h00000) && (hsize <= `DPM_HSIZE_WORD);
assign wr_en = ph_wr;
assign wr_idx = ph_idx;
assign wr_data = hwdata[7:0];
assign rd_idx = ph_idx;

always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    ph_wr <= 1'b0;
    ph_rd <= 1'b0;
    ph_idx <= {`DPM_IDX_W{1'b0}};
    hreadyout <= 1'b1;
    hresp <= `DPM_RESP_OKAY;
    hrdata <= 32'h00000000;
  end else begin
    hresp <= `DPM_RESP_OKAY;
    if (ph_rd) begin
      // one wait state, then registered read data
      hrdata <= rd_data;
      hreadyout <= 1'b1;
      ph_rd <= 1'b0;
      ph_wr <= 1'b0;
    end else if (accept) begin
      ph_wr <= hwrite && in_map;
      ph_rd <= ~hwrite;
      ph_idx <= in_map ? haddr[`DPM_ADDR_MSB:`DPM_ADDR_LSB] : {`DPM_IDX_W{1'b1}};
      hreadyout <= hwrite;
    end else begin
      ph_wr <= 1'b0;
    end
  end
end

endmodule // dpm_ahb_slv

/* design/dpm_pri_out.v */
`timescale 1ns/10ps
`include "dpm_map.vh"

module dpm_pri_out (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // result of this cycle
  input wire in_valid,
  input wire [`DPM_PRI_W-1:0] in_pri,
  input wire in_remapped,
  input wire in_bank,
  // registered result
  output reg pri_valid,
  output reg [`DPM_PRI_W-1:0] pri_value,
  output reg pri_remapped,
  output reg pri_in_bank
);

// ----------------------------------------
// result register, pri_valid for one cycle, value and flags held until next packet
// ----------------------------------------
always @(posedge clk or posedge sys_rst) begin
  if (sys_rst) begin
    pri_valid <= 1'b0;
    pri_value <= `DPM_MAP_RST;
    pri_remapped <= 1'b0;
    pri_in_bank <= 1'b0;
  end else begin
    pri_valid <= in_valid;
    if (in_valid) begin
      pri_value <= in_pri;
      pri_remapped <= in_remapped;
      pri_in_bank <= in_bank;
    end
  end
end

endmodule // dpm_pri_out

/* dv/dpm_bank_props.sv */
`timescale 1ns/10ps
`include "dpm_map.vh"

module dpm_bank_props #(
  parameter NUM_ENT = `DPM_NUM_ENT,
  parameter CNT_W = `DPM_CNT_W
) (
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // ahb-lite
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  // packet and result
  input logic pkt_valid,
  input logic pkt_is_ip,
  input logic [5:0] pkt_dscp,
  input logic pri_valid,
  input logic [`DPM_PRI_W-1:0] pri_value,
  input logic pri_remapped,
  input logic pri_in_bank
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic rd_map;
  wire take = hsel && hready && htrans[1];
  wire [2:0] dscp_cls = pkt_dscp[5:3];
  wire in_rng = pkt_dscp >= `DPM_DSCP_1A && pkt_dscp <= `DPM_DSCP_2D;

  // last taken transfer was a read of a map byte
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_map <= 1'b0;
    end else if (take) begin
      rd_map <= !hwrite && haddr[13:2] >= `DPM_IDX_1A_1B && haddr[13:2] <= `DPM_IDX_2C_2D;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_pri_follows; pkt_valid |=> pri_valid; endproperty
  property p_pri_pulse; !pkt_valid |=> !pri_valid; endproperty
  property p_remap_off;
    pri_valid && !pri_remapped && $past(pkt_is_ip) |-> pri_value == $past(dscp_cls);
  endproperty
  property p_bank_range; pri_valid && pri_remapped |-> pri_in_bank == $past(in_rng); endproperty
  property p_bank_needs_remap; pri_in_bank |-> pri_remapped; endproperty
  property p_pri_hold; !pri_valid |-> $stable(pri_value) && $stable(pri_in_bank); endproperty
  property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  property p_wr_nowait;
    take && hwrite |=> hreadyout ##1 (hreadyout != $past(take && !hwrite));
  endproperty
  property p_map_rsvd_zero;
    $rose(hreadyout) && rd_map |-> hrdata[31:8] == 24'h0 && !hrdata[7] && !hrdata[3];
  endproperty
  property p_okay; hresp == `DPM_RESP_OKAY; endproperty

  a_pri_follows: assert property (p_pri_follows)
    else $error("no result after packet");
  a_pri_pulse: assert property (p_pri_pulse)
    else $error("result without packet");
  a_remap_off: assert property (p_remap_off)
    else $error("unmapped priority is not dscp class");
  a_bank_range: assert property (p_bank_range)
    else $error("in bank flag disagrees with dscp range");
  a_bank_needs_remap: assert property (p_bank_needs_remap)
    else $error("in bank flag without remap");
  a_pri_hold: assert property (p_pri_hold)
    else $error("result changed without packet");
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");
  a_map_rsvd_zero: assert property (p_map_rsvd_zero)
    else $error("reserved map bits not zero");
  a_okay: assert property (p_okay)
    else $error("response not okay");

  c_read: cover property (take && !hwrite);
  c_in_bank: cover property (pri_valid && pri_in_bank);
  c_remap_off: cover property (pri_valid && !pri_remapped && $past(pkt_is_ip));
endmodule // dpm_bank_props

bind dpm_bank dpm_bank_props #(.NUM_ENT(NUM_ENT), .CNT_W(CNT_W)) i_dpm_bank_props (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pkt_valid(pkt_valid), .pkt_is_ip(pkt_is_ip), .pkt_dscp(pkt_dscp), .pri_valid(pri_valid),
  .pri_value(pri_value), .pri_remapped(pri_remapped), .pri_in_bank(pri_in_bank)
);

/* dv/test_dscp_priority_map_bank.sv */
`timescale 1ns/10ps
`include "dpm_map.vh"

module test_dscp_priority_map_bank;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = `DPM_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic pkt_valid = 1'b0;
  logic pkt_is_ip = 1'b0;
  logic [5:0] pkt_dscp = 6'h00;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire pri_valid;
  wire pri_remapped;
  wire pri_in_bank;
  wire [`DPM_PRI_W-1:0] pri_value;
  logic [7:0] exp_map [0:9];
  logic [31:0] rd;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  localparam int LIMIT = 20000;

  always #5 clk = ~clk;

  dpm_bank i_dpm_bank (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pkt_valid(pkt_valid),
    .pkt_is_ip(pkt_is_ip), .pkt_dscp(pkt_dscp), .pri_valid(pri_valid),
    .pri_value(pri_value), .pri_remapped(pri_remapped), .pri_in_bank(pri_in_bank)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one single ahb transfer, read data returned in rdv
  task automatic ahb(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= `DPM_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 10; k++) exp_map[k] = 8'h00;
  endtask

  task automatic read_all();
    for (int k = 0; k < 10; k++) begin
      ahb(1'b0, `DPM_IDX_1A_1B + k, 8'h00, rd);
      check("map byte", {24'h0, exp_map[k]}, rd);
    end
  endtask

  task automatic pkt(input logic ip, input logic [5:0] d, input logic [2:0] ev,
                     input logic rm, input logic ib);
    pkt_valid <= 1'b1;
    pkt_is_ip <= ip;
    pkt_dscp <= d;
    @(posedge clk);
    pkt_valid <= 1'b0;
    // result stands between this edge and the next
    @(posedge clk);
    check("pri_valid", 32'h1, {31'h0, pri_valid});
    check("pri_value", {29'h0, ev}, {29'h0, pri_value});
    check("pri flags", {30'h0, rm, ib}, {30'h0, pri_remapped, pri_in_bank});
  endtask

  // every dscp code, one idle cycle after each packet, then one non-ip packet
  task automatic sweep(input logic en);
    int k;
    logic [2:0] ev;
    logic ib;
    for (int d = 0; d < 64; d++) begin
      k = (d - `DPM_DSCP_1A) / 2;
      ib = en && d >= `DPM_DSCP_1A && d <= `DPM_DSCP_2D;
      ev = en ? 3'h0 : d[5:3];
      if (ib) ev = d[0] ? exp_map[k][6:4] : exp_map[k][2:0];
      pkt(1'b1, d[5:0], ev, en, ib);
    end
    pkt(1'b0, `DPM_DSCP_1A, 3'h0, 1'b0, 1'b0);
  endtask

  // ----------------------------------------
  // timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      final_report();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin : main
    logic [2:0] lo;
    logic [2:0] hi;
    do_reset();
    read_all();
    ahb(1'b0, `DPM_IDX_CTRL, 8'h00, rd);
    check("remap enable", 32'h0, rd);
    sweep(1'b0);
    // distinct fields, reserved bits written as one
    for (int k = 0; k < 10; k++) begin
      lo = k[2:0] ^ {k[3], 2'b00};
      hi = ~k[2:0] ^ {2'b00, k[3]};
      exp_map[k] = {1'b0, hi, 1'b0, lo};
      ahb(1'b1, `DPM_IDX_1A_1B + k, {1'b1, hi, 1'b1, lo}, rd);
    end
    read_all();
    // oversized write is ignored
    hsize <= 3'h3;
    ahb(1'b1, `DPM_IDX_1A_1B, 8'h00, rd);
    hsize <= `DPM_HSIZE_WORD;
    read_all();
    sweep(1'b0);
    ahb(1'b1, `DPM_IDX_CTRL, 8'h01, rd);
    ahb(1'b0, `DPM_IDX_CTRL, 8'h00, rd);
    check("remap enable", 32'h1, rd);
    sweep(1'b1);
    // last result and in-bank hit count
    pkt(1'b1, `DPM_DSCP_2D, exp_map[9][6:4], 1'b1, 1'b1);
    ahb(1'b0, `DPM_IDX_STAT, 8'h00, rd);
    check("status", {26'h0, 2'b11, 1'b0, exp_map[9][6:4]}, rd);
    ahb(1'b0, `DPM_IDX_CNT, 8'h00, rd);
    check("hit count", 32'h15, rd);
    ahb(1'b1, `DPM_IDX_CNT, 8'h00, rd);
    ahb(1'b0, `DPM_IDX_CNT, 8'h00, rd);
    check("hit count clear", 32'h0, rd);
    // unmapped place: write ignored, reads zero
    ahb(1'b1, 12'h3ff, 8'h5a, rd);
    ahb(1'b0, 12'h3ff, 8'h00, rd);
    check("unmapped", 32'h0, rd);
    read_all();
    // reset in mid-run clears table and enable
    do_reset();
    read_all();
    sweep(1'b0);
    final_report();
  end
endmodule // test_dscp_priority_map_bank
